// ===== common/hub_loader_consts.vh
/*
 * constants for the eeprom configuration loader: spi command and address,
 * image layout, signature values, built-in defaults, descriptor fields.
 * assumes it is included by bare name from the design files.
 */
`ifndef HUB_LOADER_CONSTS_VH
`define HUB_LOADER_CONSTS_VH

// ----------------------------------------
// spi link
// ----------------------------------------
`define SPI_READ_CMD 8'h03
`define SPI_ADDR_HI 8'h00
`define SPI_ADDR_LO 8'h00
`define SPI_DUMMY 8'h00
`define SPI_HALF_CYCLES 3'h4
`define SPI_LAST_BIT 3'h7

// ----------------------------------------
// image layout
// ----------------------------------------
`define SIG_IDENT_ONLY 8'hd0
`define SIG_CONFIGURED 8'hd2
`define IMG_SIG 4'h0
`define IMG_VID_LO 4'h1
`define IMG_VID_HI 4'h2
`define IMG_PID_LO 4'h3
`define IMG_PID_HI 4'h4
`define IMG_DID_LO 4'h5
`define IMG_DID_HI 4'h6
`define IMG_OC 4'h7
`define IMG_PORTS 4'h8
`define IMG_BUDGET 4'h9
`define IMG_CTRL_CUR 4'ha
`define IMG_PWR_DELAY 4'hb
`define IMG_OPTIONS 4'hc
`define IMG_BYTES 13

// option bits of the last image byte
`define OPT_ACCEPT_ZERO 7
`define OPT_FULL_SPEED 5
`define OPT_IND_OFF 4
`define OPT_SHARED_PWR 2
`define OPT_ONE_TT 1
`define OPT_NO_EOP 0

// ----------------------------------------
// defaults
// ----------------------------------------
`define DEF_OC_FILTER 4'h8
`define DEF_PORT_MASK 4'hf
`define DEF_BUDGET 8'h32
`define DEF_CTRL_CUR 8'h64
`define DEF_PWR_DELAY 8'h32
`define DEF_REMOVABLE 8'h00
`define DEF_NUM_PORTS 8'h04

// ----------------------------------------
// hub descriptor
// ----------------------------------------
`define HUB_DESC_TYPE 8'h29
`define ZERO_DESC_TYPE 8'h00
`define PWR_CTRL_MASK 8'hff
`define CHARS_PER_PORT_PWR 2'h1
`define CHARS_GANGED_PWR 2'h0
`define CHARS_PER_PORT_OC 2'h1
`define CHARS_GLOBAL_OC 2'h0

`endif

// ===== verilog/spi_byte_shifter.v
/*
 * spi mode 0 byte engine: shifts one byte out on mosi, msb first, and one
 * byte in from miso. assumes one clock domain; miso comes from a pin.
 */
`timescale 1ns/10ps
`include "hub_loader_consts.vh"

module spi_byte_shifter (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// byte request
	input wire start,
	input wire [7:0] txByte,
	output reg done_ff,
	output reg [7:0] rxByte_ff,
	// pins
	output reg sck_ff,
	output reg mosi_ff,
	input wire miso
);

	reg misoMeta_ff;
	reg misoSync_ff;
	reg busy_ff;
	reg [2:0] halfCnt_ff;
	reg [2:0] bitCnt_ff;
	reg [7:0] txShift_ff;

	wire halfTick = (halfCnt_ff == `SPI_HALF_CYCLES - 3'h1);

	// ----------------------------------------
	// miso synchroniser
	// ----------------------------------------
	always @(posedge clock) begin
		if (!rst_n) begin
			misoMeta_ff <= 1'b0;
			misoSync_ff <= 1'b0;
		end else begin
			misoMeta_ff <= miso;
			misoSync_ff <= misoMeta_ff;
		end
	end

	// ----------------------------------------
	// shifter
	// ----------------------------------------
	// sampling at the end of the high phase leaves room for the two-flop lag
	always @(posedge clock) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
			halfCnt_ff <= 3'h0;
			bitCnt_ff <= 3'h0;
			txShift_ff <= 8'h00;
			rxByte_ff <= 8'h00;
			sck_ff <= 1'b0;
			mosi_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (!busy_ff) begin
				if (start) begin
					busy_ff <= 1'b1;
					halfCnt_ff <= 3'h0;
					bitCnt_ff <= 3'h0;
					txShift_ff <= {txByte[6:0], 1'b0};
					mosi_ff <= txByte[7];
				end
			end else if (halfTick) begin
				halfCnt_ff <= 3'h0;
				if (!sck_ff) begin
					sck_ff <= 1'b1;
				end else begin
					sck_ff <= 1'b0;
					rxByte_ff <= {rxByte_ff[6:0], misoSync_ff};
					if (bitCnt_ff == `SPI_LAST_BIT) begin
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
					end else begin
						bitCnt_ff <= bitCnt_ff + 3'h1;
						mosi_ff <= txShift_ff[7];
						txShift_ff <= {txShift_ff[6:0], 1'b0};
					end
				end
			end else begin
				halfCnt_ff <= halfCnt_ff + 3'h1;
			end
		end
	end

endmodule

// ===== verilog/hub_eeprom_config_loader.v
/*
 * start-up loader: reads the configuration image from a serial eeprom and
 * drives the hub's identity, descriptor fields and option bits; also
 * judges the descriptor type of hub descriptor requests.
 * assumes a single 40 MHz clock, synchronous active-low reset, and an
 * eeprom with two address bytes on the other end of the spi pins.
 */
`timescale 1ns/10ps
`include "hub_loader_consts.vh"

module hub_eeprom_config_loader #(
	// identity fallbacks; values are arbitrary
	parameter [15:0] DEFAULT_VENDOR_ID = 16'h1234,
	parameter [15:0] DEFAULT_PRODUCT_ID = 16'h5678,
	parameter [15:0] DEFAULT_DEVICE_ID = 16'h0001
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// spi pins
	output reg eepromCs_n_ff,
	output wire eepromSck,
	output wire eepromMosi,
	input wire eepromMiso,
	// load status
	output reg loadDone_ff,
	output reg attachAllowed_ff,
	output reg imageConfigured_ff,
	// identity
	output reg [15:0] vendorId_ff,
	output reg [15:0] productId_ff,
	output reg [15:0] deviceId_ff,
	// settings
	output reg [3:0] enabled_port_oc_filter_ff,
	output reg [3:0] disabled_port_oc_filter_ff,
	output reg [3:0] usable_port_mask_ff,
	output reg [3:0] removable_port_mask_ff,
	output reg [7:0] upstream_current_budget_ff,
	output reg [7:0] controller_current_value_ff,
	output reg [7:0] port_power_good_delay_ff,
	output reg accept_zero_descriptor_type_ff,
	output reg restrict_to_full_speed_ff,
	output reg indicators_off_ff,
	output reg shared_power_switching_ff,
	output reg one_translator_only_ff,
	output reg suppress_frame_end_eop_ff,
	// hub descriptor fields
	output reg [7:0] descPortCount_ff,
	output reg [15:0] descHubChars_ff,
	output reg [7:0] descRemovable_ff,
	output reg [7:0] descPwrCtrlMask_ff,
	// hub descriptor request check
	input wire hubDescReq,
	input wire [7:0] hubDescType,
	output reg hubDescAccept_ff,
	output reg hubDescStall_ff
);

	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_CMD = 7'h02;
	localparam [6:0] S_AHI = 7'h04;
	localparam [6:0] S_ALO = 7'h08;
	localparam [6:0] S_DATA = 7'h10;
	localparam [6:0] S_APPLY = 7'h20;
	localparam [6:0] S_DONE = 7'h40;

	reg [6:0] state_ff;
	reg shStart_ff;
	reg [7:0] shTx_ff;
	reg [3:0] byteIdx_ff;
	reg fullImage_ff;
	reg identImage_ff;
	reg [7:0] image_ff [0:`IMG_BYTES-1];
	wire shDone;
	wire [7:0] shRx;
	integer i;

	wire [7:0] opts = image_ff[`IMG_OPTIONS];
	wire [3:0] nxt_usable = image_ff[`IMG_PORTS][7:4];
	wire [3:0] nxt_removable = image_ff[`IMG_PORTS][3:0];

	function [7:0] popcount4;
		input [3:0] m;
		begin
			popcount4 = {5'h00, {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]}
				+ {2'b00, m[3]}};
		end
	endfunction

	function [15:0] hubChars;
		input shared;
		input indOff;
		begin
			hubChars = 16'h0000;
			hubChars[1:0] = shared ? `CHARS_GANGED_PWR : `CHARS_PER_PORT_PWR;
			hubChars[4:3] = shared ? `CHARS_GLOBAL_OC : `CHARS_PER_PORT_OC;
			hubChars[7] = ~indOff;
		end
	endfunction

	spi_byte_shifter shifter (
		.clock(clock),
		.rst_n(rst_n),
		.start(shStart_ff),
		.txByte(shTx_ff),
		.done_ff(shDone),
		.rxByte_ff(shRx),
		.sck_ff(eepromSck),
		.mosi_ff(eepromMosi),
		.miso(eepromMiso)
	);

	// ----------------------------------------
	// image fetch
	// ----------------------------------------
	// one burst from address zero; the read stops early for a bad or identity-only signature
	always @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= S_IDLE;
			eepromCs_n_ff <= 1'b1;
			shStart_ff <= 1'b0;
			shTx_ff <= 8'h00;
			byteIdx_ff <= 4'h0;
			fullImage_ff <= 1'b0;
			identImage_ff <= 1'b0;
			loadDone_ff <= 1'b0;
			attachAllowed_ff <= 1'b0;
			for (i = 0; i < `IMG_BYTES; i = i + 1) begin
				image_ff[i] <= 8'h00;
			end
		end else begin
			shStart_ff <= 1'b0;
			case (state_ff)
			S_IDLE: begin
				eepromCs_n_ff <= 1'b0;
				shStart_ff <= 1'b1;
				shTx_ff <= `SPI_READ_CMD;
				state_ff <= S_CMD;
			end
			S_CMD: begin
				if (shDone) begin
					shStart_ff <= 1'b1;
					shTx_ff <= `SPI_ADDR_HI;
					state_ff <= S_AHI;
				end
			end
			S_AHI: begin
				if (shDone) begin
					shStart_ff <= 1'b1;
					shTx_ff <= `SPI_ADDR_LO;
					state_ff <= S_ALO;
				end
			end
			S_ALO: begin
				if (shDone) begin
					shStart_ff <= 1'b1;
					shTx_ff <= `SPI_DUMMY;
					byteIdx_ff <= `IMG_SIG;
					state_ff <= S_DATA;
				end
			end
			S_DATA: begin
				if (shDone) begin
					image_ff[byteIdx_ff] <= shRx;
					if (byteIdx_ff == `IMG_SIG && shRx != `SIG_IDENT_ONLY
							&& shRx != `SIG_CONFIGURED) begin
						state_ff <= S_APPLY;
					end else if (byteIdx_ff == `IMG_DID_HI && identImage_ff) begin
						state_ff <= S_APPLY;
					end else if (byteIdx_ff == `IMG_OPTIONS) begin
						state_ff <= S_APPLY;
					end else begin
						if (byteIdx_ff == `IMG_SIG) begin
							identImage_ff <= (shRx == `SIG_IDENT_ONLY);
							fullImage_ff <= (shRx == `SIG_CONFIGURED);
						end
						byteIdx_ff <= byteIdx_ff + 4'h1;
						shStart_ff <= 1'b1;
						shTx_ff <= `SPI_DUMMY;
					end
				end
			end
			S_APPLY: begin
				eepromCs_n_ff <= 1'b1;
				state_ff <= S_DONE;
			end
			S_DONE: begin
				loadDone_ff <= 1'b1;
				attachAllowed_ff <= 1'b1;
			end
			default: begin
				state_ff <= S_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------
	// apply image
	// ----------------------------------------
	// outputs hold defaults until the image is complete, so nothing half-loaded shows
	always @(posedge clock) begin
		if (!rst_n) begin
			imageConfigured_ff <= 1'b0;
			vendorId_ff <= DEFAULT_VENDOR_ID;
			productId_ff <= DEFAULT_PRODUCT_ID;
			deviceId_ff <= DEFAULT_DEVICE_ID;
			enabled_port_oc_filter_ff <= `DEF_OC_FILTER;
			disabled_port_oc_filter_ff <= `DEF_OC_FILTER;
			usable_port_mask_ff <= `DEF_PORT_MASK;
			removable_port_mask_ff <= `DEF_PORT_MASK;
			upstream_current_budget_ff <= `DEF_BUDGET;
			controller_current_value_ff <= `DEF_CTRL_CUR;
			port_power_good_delay_ff <= `DEF_PWR_DELAY;
			accept_zero_descriptor_type_ff <= 1'b0;
			restrict_to_full_speed_ff <= 1'b0;
			indicators_off_ff <= 1'b0;
			shared_power_switching_ff <= 1'b0;
			one_translator_only_ff <= 1'b0;
			suppress_frame_end_eop_ff <= 1'b0;
			descPortCount_ff <= `DEF_NUM_PORTS;
			descHubChars_ff <= hubChars(1'b0, 1'b0);
			descRemovable_ff <= `DEF_REMOVABLE;
			descPwrCtrlMask_ff <= `PWR_CTRL_MASK;
		end else if (state_ff == S_APPLY) begin
			if (identImage_ff || fullImage_ff) begin
				vendorId_ff <= {image_ff[`IMG_VID_HI], image_ff[`IMG_VID_LO]};
				productId_ff <= {image_ff[`IMG_PID_HI], image_ff[`IMG_PID_LO]};
				deviceId_ff <= {image_ff[`IMG_DID_HI], image_ff[`IMG_DID_LO]};
			end
			if (fullImage_ff) begin
				imageConfigured_ff <= 1'b1;
				enabled_port_oc_filter_ff <= image_ff[`IMG_OC][7:4];
				disabled_port_oc_filter_ff <= image_ff[`IMG_OC][3:0];
				usable_port_mask_ff <= nxt_usable;
				descPortCount_ff <= popcount4(nxt_usable);
				removable_port_mask_ff <= nxt_removable;
				descRemovable_ff <= {3'h0, nxt_removable, 1'b0};
				upstream_current_budget_ff <= image_ff[`IMG_BUDGET];
				controller_current_value_ff <= image_ff[`IMG_CTRL_CUR];
				port_power_good_delay_ff <= image_ff[`IMG_PWR_DELAY];
				// bit six and reserved bit three are simply not looked at
				accept_zero_descriptor_type_ff <= opts[`OPT_ACCEPT_ZERO];
				restrict_to_full_speed_ff <= opts[`OPT_FULL_SPEED];
				indicators_off_ff <= opts[`OPT_IND_OFF];
				shared_power_switching_ff <= opts[`OPT_SHARED_PWR];
				one_translator_only_ff <= opts[`OPT_ONE_TT];
				suppress_frame_end_eop_ff <= opts[`OPT_NO_EOP];
				descHubChars_ff <= hubChars(opts[`OPT_SHARED_PWR],
					opts[`OPT_IND_OFF]);
			end
		end
	end

	// ----------------------------------------
	// descriptor type check
	// ----------------------------------------
	always @(posedge clock) begin
		if (!rst_n) begin
			hubDescAccept_ff <= 1'b0;
			hubDescStall_ff <= 1'b0;
		end else begin
			hubDescAccept_ff <= 1'b0;
			hubDescStall_ff <= 1'b0;
			if (hubDescReq) begin
				if (hubDescType == `HUB_DESC_TYPE) begin
					hubDescAccept_ff <= 1'b1;
				end else if (hubDescType == `ZERO_DESC_TYPE
						&& accept_zero_descriptor_type_ff) begin
					hubDescAccept_ff <= 1'b1;
				end else begin
					hubDescStall_ff <= 1'b1;
				end
			end
		end
	end

endmodule

// ===== sim/hub_loader_properties.sv
/* checker for the eeprom configuration loader: descriptor answers, load
   order and fixed descriptor fields. assumes it is bound to the top module. */
`timescale 1ns/10ps

module hub_loader_properties (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// spi and load status
	input wire eepromCs_n_ff,
	input wire eepromSck,
	input wire loadDone_ff,
	input wire attachAllowed_ff,
	input wire [15:0] vendorId_ff,
	// settings
	input wire [3:0] usable_port_mask_ff,
	input wire [7:0] upstream_current_budget_ff,
	input wire [7:0] controller_current_value_ff,
	input wire accept_zero_descriptor_type_ff,
	input wire indicators_off_ff,
	input wire shared_power_switching_ff,
	// descriptor
	input wire [7:0] descPortCount_ff,
	input wire [15:0] descHubChars_ff,
	input wire [7:0] descRemovable_ff,
	input wire [7:0] descPwrCtrlMask_ff,
	input wire hubDescReq,
	input wire [7:0] hubDescType,
	input wire hubDescAccept_ff,
	input wire hubDescStall_ff
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence zeroReq;
		hubDescReq && hubDescType == 8'h00;
	endsequence
	sequence stallOnly;
		hubDescStall_ff && !hubDescAccept_ff;
	endsequence
	sequence acceptOnly;
		hubDescAccept_ff && !hubDescStall_ff;
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	zero_stall_a: assert property (
		zeroReq ##0 !accept_zero_descriptor_type_ff |=> stallOnly) else $error("zero type not stalled");
	zero_accept_a: assert property (
		zeroReq ##0 accept_zero_descriptor_type_ff |=> acceptOnly) else $error("zero type not accepted");
	hub_type_a: assert property (
		hubDescReq && hubDescType == 8'h29 |=> acceptOnly) else $error("hub type not accepted");
	pwr_mask_a: assert property (
		descPwrCtrlMask_ff == 8'hff) else $error("power mask field changed");
	port_count_a: assert property (
		descPortCount_ff == $countones(usable_port_mask_ff)) else $error("port count mismatch");
	ind_bit_a: assert property (
		descHubChars_ff[7] == !indicators_off_ff) else $error("indicator bit wrong");
	pwr_mode_a: assert property (
		descHubChars_ff[4:0] == {1'b0, !shared_power_switching_ff, 2'b00, !shared_power_switching_ff})
		else $error("power mode bits wrong");
	load_defaults_a: assert property (
		!loadDone_ff && !eepromCs_n_ff |-> descRemovable_ff == 8'h00
		&& controller_current_value_ff == 8'h64 && upstream_current_budget_ff == 8'h32)
		else $error("defaults lost during load");
	read_start_a: assert property (
		$rose(rst_n) |-> ##[1:2] !eepromCs_n_ff) else $error("read did not start");
	sck_idle_a: assert property (
		eepromCs_n_ff |-> !eepromSck) else $error("spi clock not idle low");
	attach_late_a: assert property (
		attachAllowed_ff |-> loadDone_ff && eepromCs_n_ff) else $error("attach before load end");
	ids_hold_a: assert property (
		loadDone_ff |=> loadDone_ff && $stable(vendorId_ff)) else $error("identity moved after load");
endmodule

bind hub_eeprom_config_loader hub_loader_properties checker_u (
	.clock, .rst_n, .eepromCs_n_ff, .eepromSck, .loadDone_ff, .attachAllowed_ff, .vendorId_ff,
	.usable_port_mask_ff, .upstream_current_budget_ff, .controller_current_value_ff,
	.accept_zero_descriptor_type_ff, .indicators_off_ff, .shared_power_switching_ff,
	.descPortCount_ff, .descHubChars_ff, .descRemovable_ff, .descPwrCtrlMask_ff,
	.hubDescReq, .hubDescType, .hubDescAccept_ff, .hubDescStall_ff
);

// ===== sim/spi_eeprom_model.sv
/* serial eeprom model with two address bytes, returning the image from
   address zero. assumes spi mode 0 driven by the loader. */
`timescale 1ns/10ps

module spi_eeprom_model (
	// spi pins
	input wire chipSel_n,
	input wire sck,
	input wire mosi,
	output wire miso,
	// image and observed header
	input wire [103:0] image,
	output reg [31:0] cmdSeen
);
	integer n = 0;
	reg bitOut = 1'b0;

	// released line shows the inverse, so a stale value is never read
	assign miso = chipSel_n ? ~bitOut : bitOut;

	always @(negedge chipSel_n) n = 0;

	// command and address bits, caught on rising sck
	always @(posedge sck) begin
		if (!chipSel_n && n < 24) cmdSeen = {cmdSeen[30:0], mosi};
	end

	// data leaves msb first from the falling edge that ends the last address bit
	always @(negedge sck) begin
		n = n + 1;
		if (!chipSel_n && n >= 24 && n < 128) begin
			bitOut = image[8 * ((n - 24) / 8) + 7 - (n - 24) % 8];
		end
	end
endmodule

// ===== sim/hub_eeprom_config_loader_bench.sv
/* bench for the eeprom configuration loader: random and corner images,
   every output but chip select and spi clock, and descriptor answers checked. assumes design and model. */
`timescale 1ns/10ps

module hub_eeprom_config_loader_bench;
	reg clock = 1'b0;
	reg rst_n = 1'b0;
	reg hubDescReq = 1'b0;
	reg [7:0] hubDescType = 8'h00;
	reg [103:0] image = 104'h0;
	reg [127:0] rnd;
	wire eepromCs_n_ff, eepromSck, eepromMosi, eepromMiso;
	wire loadDone_ff, attachAllowed_ff, imageConfigured_ff, hubDescAccept_ff, hubDescStall_ff;
	wire [15:0] vendorId_ff, productId_ff, deviceId_ff, descHubChars_ff;
	wire [3:0] enabled_port_oc_filter_ff, disabled_port_oc_filter_ff;
	wire [3:0] usable_port_mask_ff, removable_port_mask_ff;
	wire [7:0] upstream_current_budget_ff, controller_current_value_ff, port_power_good_delay_ff;
	wire [7:0] descPortCount_ff, descRemovable_ff, descPwrCtrlMask_ff;
	wire accept_zero_descriptor_type_ff, restrict_to_full_speed_ff, indicators_off_ff;
	wire shared_power_switching_ff, one_translator_only_ff, suppress_frame_end_eop_ff;
	wire [31:0] cmdSeen;
	integer num_errors = 0;
	integer check_count = 0;
	integer k;

	always #12.5 clock = ~clock;

	// identity fallbacks; values are arbitrary
	hub_eeprom_config_loader #(.DEFAULT_VENDOR_ID(16'h4c1e), .DEFAULT_PRODUCT_ID(16'h7a02),
		.DEFAULT_DEVICE_ID(16'h0b63)) dut_u (.clock(clock), .rst_n(rst_n),
		.eepromCs_n_ff(eepromCs_n_ff), .eepromSck(eepromSck), .eepromMosi(eepromMosi),
		.eepromMiso(eepromMiso), .loadDone_ff(loadDone_ff), .attachAllowed_ff(attachAllowed_ff),
		.imageConfigured_ff(imageConfigured_ff), .vendorId_ff(vendorId_ff),
		.productId_ff(productId_ff), .deviceId_ff(deviceId_ff),
		.enabled_port_oc_filter_ff(enabled_port_oc_filter_ff),
		.disabled_port_oc_filter_ff(disabled_port_oc_filter_ff),
		.usable_port_mask_ff(usable_port_mask_ff), .removable_port_mask_ff(removable_port_mask_ff),
		.upstream_current_budget_ff(upstream_current_budget_ff),
		.controller_current_value_ff(controller_current_value_ff),
		.port_power_good_delay_ff(port_power_good_delay_ff),
		.accept_zero_descriptor_type_ff(accept_zero_descriptor_type_ff),
		.restrict_to_full_speed_ff(restrict_to_full_speed_ff),
		.indicators_off_ff(indicators_off_ff), .shared_power_switching_ff(shared_power_switching_ff),
		.one_translator_only_ff(one_translator_only_ff),
		.suppress_frame_end_eop_ff(suppress_frame_end_eop_ff), .descPortCount_ff(descPortCount_ff),
		.descHubChars_ff(descHubChars_ff), .descRemovable_ff(descRemovable_ff),
		.descPwrCtrlMask_ff(descPwrCtrlMask_ff), .hubDescReq(hubDescReq),
		.hubDescType(hubDescType), .hubDescAccept_ff(hubDescAccept_ff),
		.hubDescStall_ff(hubDescStall_ff));

	spi_eeprom_model rom_u (.chipSel_n(eepromCs_n_ff), .sck(eepromSck), .mosi(eepromMosi),
		.miso(eepromMiso), .image(image), .cmdSeen(cmdSeen));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input [15:0] got, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	function [7:0] ones(input [3:0] m);
		ones = {6'h00, 2'b00} + m[0] + m[1] + m[2] + m[3];
	endfunction

	// one request; the answer stands only in the next cycle
	task req(input [7:0] t, input acc);
		begin
			hubDescReq <= 1'b1;
			hubDescType <= t;
			@(posedge clock);
			hubDescReq <= 1'b0;
			#1;
			chk({hubDescAccept_ff, hubDescStall_ff}, {acc, ~acc});
			@(posedge clock);
		end
	endtask

	task run_img(input [103:0] img);
		reg cfg, idv;
		reg [7:0] opt, b8;
		integer w;
		begin
			cfg = img[7:0] == 8'hd2;
			idv = cfg || img[7:0] == 8'hd0;
			opt = cfg ? img[103:96] : 8'h00;
			b8 = cfg ? img[71:64] : 8'hff;
			image <= img;
			rst_n <= 1'b0;
			repeat (10) @(posedge clock);
			rst_n <= 1'b1;
			@(posedge clock);
			req(8'h00, 1'b0);
			w = 0;
			while (loadDone_ff !== 1'b1 && w < 5000) begin
				@(posedge clock);
				w = w + 1;
			end
			if (w >= 5000) num_errors = num_errors + 1;
			#1;
			chk(attachAllowed_ff, 1'b1);
			chk(cmdSeen[23:8], 16'h0300);
			chk(cmdSeen[7:0], 8'h00);
			chk(vendorId_ff, idv ? img[23:8] : 16'h4c1e);
			chk(productId_ff, idv ? img[39:24] : 16'h7a02);
			chk(deviceId_ff, idv ? img[55:40] : 16'h0b63);
			chk({enabled_port_oc_filter_ff, disabled_port_oc_filter_ff}, cfg ? img[63:56] : 8'h88);
			chk({usable_port_mask_ff, removable_port_mask_ff}, b8);
			chk(descPortCount_ff, ones(b8[7:4]));
			chk(descRemovable_ff, cfg ? {3'b000, b8[3:0], 1'b0} : 8'h00);
			chk(upstream_current_budget_ff, cfg ? img[79:72] : 8'h32);
			chk(controller_current_value_ff, cfg ? img[87:80] : 8'h64);
			chk(port_power_good_delay_ff, cfg ? img[95:88] : 8'h32);
			chk({accept_zero_descriptor_type_ff, restrict_to_full_speed_ff, indicators_off_ff,
				shared_power_switching_ff, one_translator_only_ff, suppress_frame_end_eop_ff},
				{opt[7], opt[5:4], opt[2:0]});
			chk(descHubChars_ff, {8'h00, ~opt[4], 3'b000, ~opt[2], 2'b00, ~opt[2]});
			chk(descPwrCtrlMask_ff, 8'hff);
			chk(imageConfigured_ff, cfg);
			@(posedge clock);
			req(8'h29, 1'b1);
			req(8'h00, opt[7]);
			req({2'b01, rnd[5:0]}, 1'b0);
			$display("test done at %0t, signature %h", $time, img[7:0]);
		end
	endtask

	task end_sim;
		begin
			$display("checks %0d, mismatches %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0) begin
				$display("TB: PASS");
			end else begin
				$display("TB: FAIL");
			end
			$finish;
		end
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		k = $urandom(83);
		for (k = 0; k < 5; k = k + 1) begin
			rnd = {$urandom, $urandom, $urandom, $urandom};
			rnd[7:0] = (k < 3) ? 8'hd2 : (k == 3) ? 8'hd0 : 8'hd1;
			rnd[99] = 1'b0;
			run_img(rnd[103:0]);
		end
		run_img({96'h0, 8'hd2});
		run_img({8'hf7, 88'h0, 8'hd2});
		end_sim;
	end

	// watchdog: seven loads take well under a quarter of this
	initial begin
		#2000000;
		num_errors = num_errors + 1;
		end_sim;
	end
endmodule
